/* pkg/sdcm_defines.vh */
// constants shared by the sdram command and mode logic
`ifndef SDCM_DEFINES_VH
`define SDCM_DEFINES_VH

// commands, coded as {cs_n, ras_n, cas_n, we_n}; deselect normalised
`define SDCM_CMD_DESELECT 4'hF
`define SDCM_CMD_NO_OP 4'h7
`define SDCM_CMD_BURST_STOP 4'h6
`define SDCM_CMD_READ 4'h5
`define SDCM_CMD_WRITE 4'h4
`define SDCM_CMD_ACTIVATE 4'h3
`define SDCM_CMD_PRECHARGE 4'h2
`define SDCM_CMD_REFRESH 4'h1
`define SDCM_CMD_MODE_LOAD 4'h0

// bank states
`define SDCM_ST_IDLE 3'h0
`define SDCM_ST_ACTIVE 3'h1
`define SDCM_ST_READ 3'h2
`define SDCM_ST_WRITE 3'h3
`define SDCM_ST_READ_AUTOCLOSE 3'h4
`define SDCM_ST_WRITE_AUTOCLOSE 3'h5

// address pin roles
`define SDCM_BANK_SELECT_BIT 11
`define SDCM_AUTO_PRECHARGE_BIT 10
`define SDCM_COL_HI 7

// mode register fields and codes
`define SDCM_BL_HI 2
`define SDCM_BL_LO 0
`define SDCM_BT_BIT 3
`define SDCM_CL_HI 6
`define SDCM_CL_LO 4
`define SDCM_WM_HI 11
`define SDCM_WM_LO 9
`define SDCM_BL_1 3'h0
`define SDCM_BL_2 3'h1
`define SDCM_BL_4 3'h2
`define SDCM_BL_8 3'h3
`define SDCM_BL_FULL 3'h7
`define SDCM_CL_3 3'h3
`define SDCM_WM_SINGLE 3'h1
`define SDCM_MODE_RST 12'h020

// low-power states
`define SDCM_LP_NORMAL 2'h0
`define SDCM_LP_POWER_DOWN 2'h1
`define SDCM_LP_SELF_REFRESH 2'h2

// apb register byte addresses
`define SDCM_ADDR_MODE 8'h00
`define SDCM_ADDR_STATUS 8'h04
`define SDCM_ADDR_REFROW 8'h08

`endif

/* logic/sdcm_bank.v */
// state tracker for one dram bank
`timescale 1ns/1ps
`include "sdcm_defines.vh"
module sdcm_bank #(
   parameter [0:0] BANK_ID = 1'b0
) (
   input wire pclk,
   input wire presetn,
   input wire cmd_go,
   input wire [3:0] cmd,
   input wire bank_sel,
   input wire ap_bit,
   input wire end_go,
   input wire end_bank,
   output reg [2:0] state
);

reg [2:0] next_state;
wire hit;

assign hit = (bank_sel == BANK_ID);

// burst over: plain bursts stay open, autoclose ones go idle
function [2:0] closed;
   input [2:0] s;
   begin
      case (s)
         `SDCM_ST_READ, `SDCM_ST_WRITE: closed = `SDCM_ST_ACTIVE;
         `SDCM_ST_READ_AUTOCLOSE,
         `SDCM_ST_WRITE_AUTOCLOSE: closed = `SDCM_ST_IDLE;
         default: closed = s;
      endcase
   end
endfunction

always @* begin
   next_state = state;
   if (end_go && end_bank == BANK_ID) begin
      next_state = closed(state);
   end
   if (cmd_go) begin
      case (cmd)
         `SDCM_CMD_ACTIVATE: begin
            if (hit && next_state == `SDCM_ST_IDLE) begin
               next_state = `SDCM_ST_ACTIVE;
            end
         end
         `SDCM_CMD_READ: begin
            if (!hit) begin
               next_state = closed(next_state);
            end else if (next_state != `SDCM_ST_IDLE) begin
               next_state = ap_bit ? `SDCM_ST_READ_AUTOCLOSE :
                            `SDCM_ST_READ;
            end
         end
         `SDCM_CMD_WRITE: begin
            if (!hit) begin
               next_state = closed(next_state);
            end else if (next_state != `SDCM_ST_IDLE) begin
               next_state = ap_bit ? `SDCM_ST_WRITE_AUTOCLOSE :
                            `SDCM_ST_WRITE;
            end
         end
         `SDCM_CMD_BURST_STOP: begin
            next_state = closed(next_state);
         end
         `SDCM_CMD_PRECHARGE: begin
            if (ap_bit || hit) begin
               next_state = `SDCM_ST_IDLE;
            end
         end
         default: begin
            next_state = next_state;
         end
      endcase
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      state <= `SDCM_ST_IDLE;
   end else begin
      state <= next_state;
   end
end

endmodule

/* logic/sdcm_core.v */
// sdram command decode, bank tracking, bursts and mode register
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sdcm_defines.vh"
// What this block does
// - clock-gate rise wakes input buffers at once, no clock edge.
// - strobes decode each edge into the nine commands.
// - each bank tracked alone; a read or write to one bank ends any burst in the other.
// - read with auto-precharge bit high enters read-autoclose state.
// - write with auto-precharge bit high enters write-autoclose state.
// - read and write ignore address lines eight and nine.
// - mode load captures address lines zero to eleven as code.
// - read data appears three clocks after read command at cas latency three, two clocks at any other latency code.
// - burst starts at given column; later addresses made internally.
// - burst lengths one, two, four, eight or full page.
// - burst order sequential or interleaved per burst type.
// - write mode code zero gives burst writes starting at command.
// - write starts at column and bank sampled on command cycle.
// - write mode code one stores one word per write.
// - top address line selects the bank for activate, read, write and single-bank precharge.
// - auto-refresh makes row internally, ignoring address pins.
module sdcm_core (
   input wire pclk,
   input wire presetn,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [11:0] addr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output wire [2:0] bank0_state,
   output wire [2:0] bank1_state,
   output reg wr_strobe,
   output reg [7:0] wr_col,
   output reg wr_bank,
   output reg rd_valid,
   output reg [7:0] rd_col,
   output reg rd_bank,
   output reg buffers_awake,
   output reg power_down,
   output reg self_refresh
);

reg cke_prev;
reg [1:0] lp;
reg [1:0] next_lp;
reg [11:0] mode_reg;
reg [10:0] refresh_row;
reg busy;
reg bwe;
reg bbank;
reg btype;
reg bfull;
reg [7:0] bstart;
reg [7:0] blast;
reg [7:0] cnt;
reg next_busy;
reg [7:0] next_cnt;
reg iss_go;
reg iss_we;
reg [7:0] iss_col;
reg st0_v;
reg [7:0] st0_col;
reg st0_bank;
reg st1_v;
reg [7:0] st1_col;
reg st1_bank;
reg [3:0] cmd;
reg [7:0] new_last;
reg new_full;
reg single_wr;
wire cmd_go;
wire is_rw;
wire stop;
wire run;
wire burst_end;
wire both_idle;
wire bank_sel;
wire ap_bit;
wire [7:0] col;
wire cl3;
wire apb_wr;

always @* begin
   if (cs_n) begin
      cmd = `SDCM_CMD_DESELECT;
   end else begin
      cmd = {1'b0, ras_n, cas_n, we_n};
   end
end

assign bank_sel = addr[`SDCM_BANK_SELECT_BIT];
assign ap_bit = addr[`SDCM_AUTO_PRECHARGE_BIT];
assign col = addr[`SDCM_COL_HI:0];
assign cmd_go = cke_prev && (lp == `SDCM_LP_NORMAL);
assign is_rw = cmd_go && (cmd == `SDCM_CMD_READ ||
                          cmd == `SDCM_CMD_WRITE);
assign both_idle = (bank0_state == `SDCM_ST_IDLE) &&
                   (bank1_state == `SDCM_ST_IDLE);
assign cl3 = (mode_reg[`SDCM_CL_HI:`SDCM_CL_LO] == `SDCM_CL_3);

function [7:0] len_last;
   input [2:0] bl;
   begin
      case (bl)
         `SDCM_BL_2: len_last = 8'h01;
         `SDCM_BL_4: len_last = 8'h03;
         `SDCM_BL_8: len_last = 8'h07;
         `SDCM_BL_FULL: len_last = 8'hFF;
         default: len_last = 8'h00;
      endcase
   end
endfunction

function [7:0] burst_col;
   input [7:0] start;
   input [7:0] idx;
   input [7:0] mask;
   input inter;
   reg [7:0] step;
   begin
      step = inter ? (start ^ idx) : (start + idx);
      burst_col = (start & ~mask) | (step & mask);
   end
endfunction

always @* begin
   single_wr = (cmd == `SDCM_CMD_WRITE) &&
      (mode_reg[`SDCM_WM_HI:`SDCM_WM_LO] == `SDCM_WM_SINGLE);
   new_last = single_wr ? 8'h00 :
      len_last(mode_reg[`SDCM_BL_HI:`SDCM_BL_LO]);
   new_full = !single_wr &&
      (mode_reg[`SDCM_BL_HI:`SDCM_BL_LO] == `SDCM_BL_FULL);
end

assign stop = cmd_go && ((cmd == `SDCM_CMD_BURST_STOP) ||
   (cmd == `SDCM_CMD_PRECHARGE && (ap_bit || bank_sel == bbank)));
assign run = busy && cke_prev && !is_rw && !stop;
assign burst_end = run && !bfull && (cnt == blast);

always @* begin
   next_busy = busy;
   next_cnt = cnt;
   iss_go = 1'b0;
   iss_we = bwe;
   iss_col = col;
   if (is_rw) begin
      next_busy = 1'b1;
      next_cnt = 8'h00;
      iss_go = 1'b1;
      iss_we = (cmd == `SDCM_CMD_WRITE);
      iss_col = col;
   end else if (stop) begin
      next_busy = 1'b0;
   end else if (run) begin
      if (burst_end) begin
         next_busy = 1'b0;
      end else begin
         next_cnt = cnt + 8'h01;
         iss_go = 1'b1;
         iss_col = burst_col(bstart, next_cnt, blast, btype);
      end
   end
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      bwe <= 1'b0;
      bbank <= 1'b0;
      btype <= 1'b0;
      bfull <= 1'b0;
      bstart <= 8'h00;
      blast <= 8'h00;
   end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      if (is_rw) begin
         bwe <= (cmd == `SDCM_CMD_WRITE);
         bbank <= bank_sel;
         btype <= mode_reg[`SDCM_BT_BIT];
         bfull <= new_full;
         bstart <= col;
         blast <= new_last;
      end
   end
end

// word streams; reads pass a cas-latency delay line
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      wr_strobe <= 1'b0;
      wr_col <= 8'h00;
      wr_bank <= 1'b0;
      st0_v <= 1'b0;
      st0_col <= 8'h00;
      st0_bank <= 1'b0;
      st1_v <= 1'b0;
      st1_col <= 8'h00;
      st1_bank <= 1'b0;
      rd_valid <= 1'b0;
      rd_col <= 8'h00;
      rd_bank <= 1'b0;
   end else begin
      wr_strobe <= iss_go && iss_we;
      wr_col <= iss_col;
      wr_bank <= is_rw ? bank_sel : bbank;
      st0_v <= iss_go && !iss_we;
      st0_col <= iss_col;
      st0_bank <= is_rw ? bank_sel : bbank;
      st1_v <= st0_v;
      st1_col <= st0_col;
      st1_bank <= st0_bank;
      rd_valid <= cl3 ? st1_v : st0_v;
      rd_col <= cl3 ? st1_col : st0_col;
      rd_bank <= cl3 ? st1_bank : st0_bank;
   end
end

sdcm_bank #(.BANK_ID(1'b0)) u_bank0 (
   .pclk(pclk),
   .presetn(presetn),
   .cmd_go(cmd_go),
   .cmd(cmd),
   .bank_sel(bank_sel),
   .ap_bit(ap_bit),
   .end_go(burst_end),
   .end_bank(bbank),
   .state(bank0_state)
);

sdcm_bank #(.BANK_ID(1'b1)) u_bank1 (
   .pclk(pclk),
   .presetn(presetn),
   .cmd_go(cmd_go),
   .cmd(cmd),
   .bank_sel(bank_sel),
   .ap_bit(ap_bit),
   .end_go(burst_end),
   .end_bank(bbank),
   .state(bank1_state)
);

// low-power entry and exit
always @* begin
   next_lp = lp;
   case (lp)
      `SDCM_LP_NORMAL: begin
         if (cke_prev && !cke && both_idle && !busy) begin
            if (cmd_go && cmd == `SDCM_CMD_REFRESH) begin
               next_lp = `SDCM_LP_SELF_REFRESH;
            end else begin
               next_lp = `SDCM_LP_POWER_DOWN;
            end
         end
      end
      `SDCM_LP_POWER_DOWN, `SDCM_LP_SELF_REFRESH: begin
         if (cke) begin
            next_lp = `SDCM_LP_NORMAL;
         end
      end
      default: begin
         next_lp = `SDCM_LP_NORMAL;
      end
   endcase
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      cke_prev <= 1'b0;
      lp <= `SDCM_LP_NORMAL;
      power_down <= 1'b0;
      self_refresh <= 1'b0;
   end else begin
      cke_prev <= cke;
      lp <= next_lp;
      power_down <= (next_lp == `SDCM_LP_POWER_DOWN);
      self_refresh <= (next_lp == `SDCM_LP_SELF_REFRESH);
   end
end

always @(posedge pclk or negedge presetn or posedge cke) begin
   if (!presetn) begin
      buffers_awake <= 1'b0;
   end else if (cke) begin
      buffers_awake <= 1'b1;
   end else begin
      buffers_awake <= 1'b0;
   end
end

assign apb_wr = psel && penable && pwrite && (paddr == `SDCM_ADDR_MODE);

// mode register and refresh row
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      mode_reg <= `SDCM_MODE_RST;
      refresh_row <= 11'h000;
   end else begin
      if (cmd_go && cmd == `SDCM_CMD_MODE_LOAD && both_idle) begin
         mode_reg <= addr;
      end else if (apb_wr) begin
         mode_reg <= pwdata[11:0];
      end
      if (cmd_go && cmd == `SDCM_CMD_REFRESH) begin
         refresh_row <= refresh_row + 11'h001;
      end
   end
end

// apb slave: data prepared in setup phase, no wait states
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
         pslverr <= 1'b0;
         case (paddr)
            `SDCM_ADDR_MODE: prdata <= {20'h00000, mode_reg};
            `SDCM_ADDR_STATUS: prdata <= {21'h000000, lp, busy,
               1'b0, bank1_state, 1'b0, bank0_state};
            `SDCM_ADDR_REFROW: prdata <= {21'h000000, refresh_row};
            default: begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end
end

endmodule

/* testbench/sdcm_core_chk.sv */
// port assertions for the sdram command logic
`timescale 1ns/1ps
`include "sdcm_defines.vh"
module sdcm_core_chk (
   input wire pclk,
   input wire presetn,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [11:0] addr,
   input wire [2:0] bank0_state,
   input wire [2:0] bank1_state,
   input wire wr_strobe,
   input wire [7:0] wr_col,
   input wire wr_bank,
   input wire rd_valid,
   input wire buffers_awake,
   input wire power_down,
   input wire self_refresh
);
   reg cke_q;
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire go = cke_q && !power_down && !self_refresh;
   wire rdc = go && cmd == `SDCM_CMD_READ;
   wire wrc = go && cmd == `SDCM_CMD_WRITE;
   wire act = go && cmd == `SDCM_CMD_ACTIVATE;
   wire b0i = bank0_state == `SDCM_ST_IDLE;
   wire b0a = bank0_state == `SDCM_ST_ACTIVE;
   wire b1i = bank1_state == `SDCM_ST_IDLE;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         cke_q <= 1'b0;
      else
         cke_q <= cke;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_act;
      act && !addr[11] && b0i |=> b0a;
   endproperty
   a_act: assert property (p_act) else $error("no activate");
   property p_other;
      act && addr[11] && (b0i || b0a) |=> $stable(bank0_state);
   endproperty
   a_other: assert property (p_other) else $error("bank0 moved");
   property p_rdac;
      rdc && addr[10] && !addr[11] && b0a |=>
         bank0_state == `SDCM_ST_READ_AUTOCLOSE;
   endproperty
   a_rdac: assert property (p_rdac) else $error("read close");
   property p_wrac;
      wrc && addr[10] && !addr[11] && b0a |=>
         bank0_state == `SDCM_ST_WRITE_AUTOCLOSE;
   endproperty
   a_wrac: assert property (p_wrac) else $error("write close");
   property p_rd;
      rdc && !addr[10] && !addr[11] && b0a |=>
         bank0_state == `SDCM_ST_READ;
   endproperty
   a_rd: assert property (p_rd) else $error("plain read");
   property p_precharge_both_cmd;
      go && cmd == `SDCM_CMD_PRECHARGE && addr[10] |=> b0i && b1i;
   endproperty
   a_precharge_both_cmd: assert property (p_precharge_both_cmd) else $error("not idle");
   property p_wcol;
      wrc |=> wr_strobe && wr_col == $past(addr[7:0])
         && wr_bank == $past(addr[11]);
   endproperty
   a_wcol: assert property (p_wcol) else $error("write start");
   property p_cl;
      rdc |-> ##[2:3] rd_valid;
   endproperty
   a_cl: assert property (p_cl) else $error("read latency");
   property p_wake;
      $rose(cke) |-> buffers_awake;
   endproperty
   a_wake: assert property (p_wake) else $error("not awake");
   c_wr: cover property (wrc);
   c_rdac: cover property (rdc && addr[10]);
   c_pd: cover property (power_down);
   c_sr: cover property (self_refresh);
endmodule
bind sdcm_core sdcm_core_chk u_sdcm_core_chk (.pclk, .presetn, .cke,
   .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank0_state, .bank1_state,
   .wr_strobe, .wr_col, .wr_bank, .rd_valid, .buffers_awake, .power_down,
   .self_refresh);

/* testbench/sdcm_ctrl_model.sv */
// memory controller model driving the command pins
`timescale 1ns/1ps
`include "sdcm_defines.vh"
module sdcm_ctrl_model (
   input wire pclk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [11:0] addr
);
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = `SDCM_CMD_DESELECT;
      addr = 12'h000;
   end
   task automatic cmd(input logic [3:0] c, input logic [11:0] a);
      @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      addr <= a;
      @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} <= `SDCM_CMD_DESELECT;
      addr <= ~a;
   endtask
   task automatic mode(input logic [11:0] op);
      cmd(`SDCM_CMD_MODE_LOAD, op);
      repeat (2) @(posedge pclk);
   endtask
   task automatic init(input logic [11:0] op);
      repeat (20000) @(posedge pclk);
      cmd(`SDCM_CMD_PRECHARGE, 12'h400);
      repeat (2) cmd(`SDCM_CMD_REFRESH, 12'h000);
      mode(op);
   endtask
   task automatic nap(input int n, input logic [3:0] c);
      @(posedge pclk);
      cke <= 1'b0;
      {cs_n, ras_n, cas_n, we_n} <= c;
      @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} <= `SDCM_CMD_DESELECT;
      repeat (n - 1) @(posedge pclk);
   endtask
   task automatic wake();
      @(posedge pclk);
      cke <= 1'b1;
   endtask
endmodule

/* testbench/sdcm_core_bench.sv */
// self-checking bench for the sdram command logic
`timescale 1ns/1ps
`include "sdcm_defines.vh"
module sdcm_core_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, wr_col, rd_col;
   logic [31:0] pwdata, prdata, rd;
   logic cke, cs_n, ras_n, cas_n, we_n, wr_strobe, wr_bank, rd_valid;
   logic rd_bank, buffers_awake, power_down, self_refresh;
   logic [11:0] addr;
   logic [2:0] b0, b1;
   logic [8:0] wq[$], rq[$];
   int miscompares = 0;
   int n_compared = 0;
   sdcm_ctrl_model u_sdcm_ctrl_model (.pclk, .cke, .cs_n, .ras_n,
      .cas_n, .we_n, .addr);
   sdcm_core u_sdcm_core (.pclk, .presetn, .cke, .cs_n, .ras_n, .cas_n,
      .we_n, .addr, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .bank0_state(b0), .bank1_state(b1), .wr_strobe,
      .wr_col, .wr_bank, .rd_valid, .rd_col, .rd_bank, .buffers_awake,
      .power_down, .self_refresh);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (wr_strobe === 1'b1) wq.push_back({wr_bank, wr_col});
      if (rd_valid === 1'b1) rq.push_back({rd_bank, rd_col});
   end
   task automatic close_out();
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic st(input logic [2:0] e0, input logic [2:0] e1);
      #1;
      chk("bank0", e0, b0);
      chk("bank1", e1, b1);
   endtask
   task automatic qchk(input string n, ref logic [8:0] q[$],
         input logic [8:0] e[$]);
      chk({n, " count"}, e.size(), q.size());
      foreach (e[i]) if (i < q.size()) chk(n, e[i], q[i]);
      q.delete();
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SDCM_ADDR_MODE, 32'h0);
      chk("mode reset", 32'h20, rd);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped error", 32'h1, er);
      apb(1'b1, `SDCM_ADDR_MODE, 32'h33);
      apb(1'b0, `SDCM_ADDR_MODE, 32'h0);
      chk("mode write", 32'h33, rd);
      u_sdcm_ctrl_model.init(12'h021);
      apb(1'b0, `SDCM_ADDR_MODE, 32'h0);
      chk("mode load", 32'h21, rd);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_ACTIVATE, 12'h000);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_ACTIVATE, 12'h800);
      st(3'h1, 3'h1);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_WRITE, 12'h305);
      st(3'h3, 3'h1);
      repeat (5) @(posedge pclk);
      qchk("write cols", wq, '{9'h005, 9'h004});
      st(3'h1, 3'h1);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_READ, 12'hF09);
      st(3'h1, 3'h4);
      repeat (6) @(posedge pclk);
      qchk("read cols", rq, '{9'h109, 9'h108});
      st(3'h1, 3'h0);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_PRECHARGE, 12'h400);
      st(3'h0, 3'h0);
      u_sdcm_ctrl_model.mode(12'h22A);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_ACTIVATE, 12'h000);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_ACTIVATE, 12'h800);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_WRITE, 12'h405);
      st(3'h5, 3'h1);
      repeat (5) @(posedge pclk);
      qchk("single write", wq, '{9'h005});
      st(3'h0, 3'h1);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_WRITE, 12'h810);
      st(3'h0, 3'h3);
      repeat (5) @(posedge pclk);
      qchk("write bank", wq, '{9'h110});
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_READ, 12'h806);
      st(3'h0, 3'h2);
      repeat (8) @(posedge pclk);
      qchk("interleave", rq, '{9'h106, 9'h107, 9'h104, 9'h105});
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_PRECHARGE, 12'h800);
      st(3'h0, 3'h0);
      u_sdcm_ctrl_model.mode(12'h030);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_ACTIVATE, 12'h000);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_READ, 12'h40C);
      repeat (2) @(posedge pclk);
      #1;
      chk("cas latency 3", 32'h1, rd_valid);
      repeat (3) @(posedge pclk);
      qchk("latency col", rq, '{9'h00C});
      st(3'h0, 3'h0);
      u_sdcm_ctrl_model.cmd(`SDCM_CMD_REFRESH, 12'hFFF);
      apb(1'b0, `SDCM_ADDR_REFROW, 32'h0);
      chk("refresh row", 32'h3, rd);
      u_sdcm_ctrl_model.nap(3, `SDCM_CMD_DESELECT);
      #1;
      chk("power down", 32'h1, power_down);
      chk("asleep", 32'h0, buffers_awake);
      apb(1'b0, `SDCM_ADDR_STATUS, 32'h0);
      chk("status", 32'h200, rd);
      u_sdcm_ctrl_model.wake();
      #1;
      chk("awake", 32'h1, buffers_awake);
      repeat (3) @(posedge pclk);
      #1;
      chk("power up", 32'h0, power_down);
      u_sdcm_ctrl_model.nap(3, `SDCM_CMD_REFRESH);
      #1;
      chk("self refresh", 32'h1, self_refresh);
      chk("no power down", 32'h0, power_down);
      u_sdcm_ctrl_model.wake();
      repeat (3) @(posedge pclk);
      #1;
      chk("refresh exit", 32'h0, self_refresh);
      close_out();
   end
endmodule
